// ==== rtl/dma_acq_pkg.sv ====
// Constants and types shared by the bus acquisition block
// How it works
// - Request the bus on FIFO threshold or any descriptor area access
// - Drop the request between areas, then request afresh for the next
// - Protocol select pin: 0 two-way hold, 1 three-way grant handshake
// - One idle holding state after the last data state on release
// - Two-way: raise hold, wait acknowledge, transfer while it stays
// - Two-way: acknowledge removed early preempts; request again later to finish
// - Hold acknowledge sampled on the rising clock edge
// - Hold raised on falling edge, or rising edge when late bit set
// - Hold is not raised while acknowledge is still active
// - Preempted in match table: leave bus, keep hold, status parked
// - Preempted in descriptor area: leave bus, drop hold, retry after one clock
// - Preempted in buffer area: request again only when threshold demands
// - Three-way: request by driving bus request low, arbiter grants
// - After grant wait for grant ack, strobe, size acks, async terminate free
// - Three-way: ownership kept until own grant acknowledge drops
// - Register accesses are single; all master accesses are DMA blocks
// - Exact block: words per block equal the programmed FIFO threshold
// - Empty/fill: fill transmit FIFO or empty receive FIFO completely
// - Descriptor blocks: 4 resource, 7 receive, 2/3/6 transmit, 4 match
package dma_acq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] SECOND_DATA_CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // Data config fields
  localparam int TX_THR_LSB = 0;
  localparam int RX_THR_LSB = 4;
  localparam int FILL_MODE_BIT = 8;
  localparam int ASYNC_MODE_BIT = 9;
  // Second data config fields
  localparam int LATE_REQUEST_EDGE_BIT = 0;

  // Reset values
  localparam logic [3:0] TX_THR_RESET = 4'h4;
  localparam logic [3:0] RX_THR_RESET = 4'h4;

  // ----------------------------------------------------------------
  // Descriptor block lengths in accesses
  // ----------------------------------------------------------------
  localparam logic [3:0] RESOURCE_ACCESSES = 4'h4;
  localparam logic [3:0] RX_DESC_ACCESSES = 4'h7;
  localparam logic [3:0] TX_DESC_SHORT = 4'h2;
  localparam logic [3:0] TX_DESC_MID = 4'h3;
  localparam logic [3:0] TX_DESC_LONG = 4'h6;
  localparam logic [3:0] MATCH_ACCESSES = 4'h4;

  // Memory areas, in the order of the descriptor request code first
  typedef enum logic [2:0] {
    AREA_RESOURCE,
    AREA_RX_DESC,
    AREA_TX_DESC,
    AREA_MATCH,
    AREA_RX_BUF,
    AREA_TX_BUF
  } area_type;

  // Acquisition sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARB,
    ST_REQ,
    ST_WAIT_FREE,
    ST_DATA,
    ST_PARKED,
    ST_RELEASE
  } fsm_type;

endpackage : dma_acq_pkg

// ==== rtl/dma_bus_master_acquisition.sv ====
// Bus acquisition and block transfer sequencer of the DMA master
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module dma_bus_master_acquisition #(
  parameter int FIFO_DEPTH = 16,
  parameter int LEVEL_W = 5
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [31:0] REG_RDATA,
  // Protocol select pin
  input wire logic BUS_PROTOCOL_SELECT,
  // Two-way handshake
  output logic HOLD_REQUEST,
  input wire logic HOLD_ACKNOWLEDGE,
  // Three-way handshake
  output logic BUS_REQUEST_N,
  input wire logic BUS_GRANT_N,
  input wire logic GRANT_ACKNOWLEDGE_N_IN,
  output logic GRANT_ACKNOWLEDGE_N_OUT,
  output logic GRANT_ACKNOWLEDGE_N_OE,
  input wire logic ADDRESS_STROBE_N,
  input wire logic [1:0] DATA_SIZE_ACK_N,
  input wire logic SYNC_CYCLE_TERMINATE_N,
  // FIFO levels and descriptor requests from the controller
  input wire logic [LEVEL_W-1:0] TX_LEVEL,
  input wire logic [LEVEL_W-1:0] RX_LEVEL,
  input wire logic DESC_REQ,
  input wire logic [1:0] DESC_AREA,
  input wire logic [1:0] TX_DESC_LEN,
  // Memory cycle engine
  output logic BUS_OWNED,
  output logic MEM_CYCLE,
  output logic [2:0] MEM_AREA,
  output logic AREA_VALID,
  input wire logic CYCLE_DONE,
  output logic DESC_DONE
);
  import dma_acq_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16) begin : g_depth_check
    $error("FIFO_DEPTH must lie between 2 and 16");
  end
  if (LEVEL_W < $clog2(FIFO_DEPTH + 1)) begin : g_level_check
    $error("LEVEL_W too narrow for FIFO_DEPTH");
  end

  localparam int PIN_W = 8;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = '0;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = LEVEL_W'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    fsm_type fsm;
    area_type area;
    logic [3:0] remaining;
    logic resume;
    logic hold_req;
    logic br_n;
    logic grant_acknowledge_n;
    logic mem_cycle;
    logic area_valid;
    logic desc_done;
    logic [3:0] tx_thr;
    logic [3:0] rx_thr;
    logic fill_mode;
    logic async_mode;
    logic late_edge;
    logic [31:0] rdata;
  } state_type;

  state_type state;
  state_type next_state;
  logic hold_fall;

  // Synchronised pin levels
  logic sel_s;
  logic hold_acknowledge_s;
  logic bg_n_s;
  logic grant_acknowledge_n_n_s;
  logic as_n_s;
  logic [1:0] ds_n_s;
  logic sync_cycle_terminate_n_n_s;
  assign sel_s = state.sync2[0];
  assign hold_acknowledge_s = state.sync2[1];
  assign bg_n_s = state.sync2[2];
  assign grant_acknowledge_n_n_s = state.sync2[3];
  assign as_n_s = state.sync2[4];
  assign ds_n_s = state.sync2[6:5];
  assign sync_cycle_terminate_n_n_s = state.sync2[7];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rx_due;
    logic tx_due;
    logic bus_free;
    logic block_end;
    logic [3:0] desc_len;
    next_state = state;
    rx_due = 1'b0;
    tx_due = 1'b0;
    bus_free = 1'b0;
    block_end = 1'b0;
    desc_len = RESOURCE_ACCESSES;
    next_state.desc_done = 1'b0;

    // Two flip-flop synchronisers for every pin
    next_state.sync1 = {SYNC_CYCLE_TERMINATE_N, DATA_SIZE_ACK_N, ADDRESS_STROBE_N,
                        GRANT_ACKNOWLEDGE_N_IN, BUS_GRANT_N, HOLD_ACKNOWLEDGE,
                        BUS_PROTOCOL_SELECT};
    next_state.sync2 = state.sync1;

    // Threshold conditions
    rx_due = (RX_LEVEL >= LEVEL_W'(state.rx_thr)) && (RX_LEVEL != LEVEL_ZERO);
    tx_due = ((LEVEL_FULL - TX_LEVEL) >= LEVEL_W'(state.tx_thr))
             && (TX_LEVEL != LEVEL_FULL);

    // Descriptor block length by area
    unique case (DESC_AREA)
      2'h0: desc_len = RESOURCE_ACCESSES;
      2'h1: desc_len = RX_DESC_ACCESSES;
      2'h2: begin
        unique case (TX_DESC_LEN)
          2'h0: desc_len = TX_DESC_SHORT;
          2'h1: desc_len = TX_DESC_MID;
          default: desc_len = TX_DESC_LONG;
        endcase
      end
      default: desc_len = MATCH_ACCESSES;
    endcase

    // Previous master and slave have let go of the bus
    bus_free = grant_acknowledge_n_n_s && as_n_s && (ds_n_s == 2'h3)
               && (sync_cycle_terminate_n_n_s || !state.async_mode);

    // Block is complete at the start of a word slot
    if (state.fill_mode && state.area == AREA_RX_BUF) begin
      block_end = (RX_LEVEL == LEVEL_ZERO);
    end else if (state.fill_mode && state.area == AREA_TX_BUF) begin
      block_end = (TX_LEVEL == LEVEL_FULL);
    end else begin
      block_end = (state.remaining == 4'h0);
    end

    unique case (state.fsm)
      // Pick the next area: descriptors first, then receive, then transmit
      ST_IDLE: begin
        next_state.hold_req = 1'b0;
        next_state.br_n = 1'b1;
        next_state.area_valid = 1'b0;
        if (DESC_REQ) begin
          next_state.area = area_type'({1'b0, DESC_AREA});
          next_state.remaining = desc_len;
          next_state.fsm = ST_ARB;
        end else if (rx_due) begin
          next_state.area = AREA_RX_BUF;
          next_state.remaining = state.rx_thr;
          next_state.fsm = ST_ARB;
        end else if (tx_due) begin
          next_state.area = AREA_TX_BUF;
          next_state.remaining = state.tx_thr;
          next_state.fsm = ST_ARB;
        end
      end
      // Hold off the request while acknowledge is still high
      ST_ARB: begin
        if (sel_s) begin
          next_state.br_n = 1'b0;
          next_state.fsm = ST_REQ;
        end else if (!hold_acknowledge_s) begin
          next_state.hold_req = 1'b1;
          next_state.fsm = ST_REQ;
        end
      end
      // Wait for acknowledge or grant
      ST_REQ: begin
        if (sel_s) begin
          if (!bg_n_s) begin
            next_state.fsm = ST_WAIT_FREE;
          end
        end else if (hold_acknowledge_s) begin
          next_state.fsm = ST_DATA;
          next_state.area_valid = 1'b1;
        end
      end
      // Three-way: wait for the bus to fall quiet, then take it
      ST_WAIT_FREE: begin
        if (bus_free) begin
          next_state.grant_acknowledge_n = 1'b1;
          next_state.br_n = 1'b1;
          next_state.area_valid = 1'b1;
          next_state.fsm = ST_DATA;
        end
      end
      // Block transfer, one memory cycle per word
      ST_DATA: begin
        if (!sel_s && !hold_acknowledge_s) begin
          // Two-way preemption
          next_state.mem_cycle = 1'b0;
          next_state.area_valid = 1'b0;
          // A word that ends in the preempting cycle is done and is not repeated
          if (state.mem_cycle && CYCLE_DONE && state.remaining != 4'h0) begin
            next_state.remaining = state.remaining - 4'h1;
          end
          if (state.area == AREA_MATCH) begin
            next_state.fsm = ST_PARKED;
          end else begin
            next_state.hold_req = 1'b0;
            next_state.resume = (state.area != AREA_RX_BUF)
                                && (state.area != AREA_TX_BUF);
            next_state.fsm = ST_RELEASE;
          end
        end else if (state.mem_cycle) begin
          if (CYCLE_DONE) begin
            next_state.mem_cycle = 1'b0;
            if (state.remaining != 4'h0) begin
              next_state.remaining = state.remaining - 4'h1;
            end
          end
        end else if (block_end) begin
          // Normal end of the block
          next_state.hold_req = 1'b0;
          next_state.resume = 1'b0;
          next_state.area_valid = 1'b0;
          next_state.desc_done = (state.area != AREA_RX_BUF)
                                 && (state.area != AREA_TX_BUF);
          next_state.fsm = ST_RELEASE;
        end else begin
          next_state.mem_cycle = 1'b1;
        end
      end
      // Off the bus with hold kept high until acknowledge returns
      ST_PARKED: begin
        if (hold_acknowledge_s) begin
          next_state.area_valid = 1'b1;
          next_state.fsm = ST_DATA;
        end
      end
      // Holding state: drivers off, three-way ownership given up after it
      ST_RELEASE: begin
        next_state.grant_acknowledge_n = 1'b0;
        next_state.area_valid = 1'b0;
        if (state.resume && !hold_acknowledge_s) begin
          next_state.resume = 1'b0;
          next_state.hold_req = 1'b1;
          next_state.fsm = ST_REQ;
        end else if (state.resume) begin
          next_state.resume = 1'b0;
          next_state.fsm = ST_ARB;
        end else begin
          next_state.fsm = ST_IDLE;
        end
      end
    endcase

    // Single register accesses from software
    if (REG_WRITE) begin
      unique case (REG_ADDR)
        DATA_CONFIG_OFFSET: begin
          next_state.tx_thr = REG_WDATA[TX_THR_LSB +: 4];
          next_state.rx_thr = REG_WDATA[RX_THR_LSB +: 4];
          next_state.fill_mode = REG_WDATA[FILL_MODE_BIT];
          next_state.async_mode = REG_WDATA[ASYNC_MODE_BIT];
        end
        SECOND_DATA_CONFIG_OFFSET: begin
          next_state.late_edge = REG_WDATA[LATE_REQUEST_EDGE_BIT];
        end
        default: begin
        end
      endcase
    end
    next_state.rdata = 32'h0;
    if (REG_READ) begin
      unique case (REG_ADDR)
        DATA_CONFIG_OFFSET: begin
          next_state.rdata[TX_THR_LSB +: 4] = state.tx_thr;
          next_state.rdata[RX_THR_LSB +: 4] = state.rx_thr;
          next_state.rdata[FILL_MODE_BIT] = state.fill_mode;
          next_state.rdata[ASYNC_MODE_BIT] = state.async_mode;
        end
        SECOND_DATA_CONFIG_OFFSET: begin
          next_state.rdata[LATE_REQUEST_EDGE_BIT] = state.late_edge;
        end
        STATUS_OFFSET: begin
          next_state.rdata[2:0] = state.fsm;
          next_state.rdata[6:4] = state.area;
          next_state.rdata[11:8] = state.remaining;
          next_state.rdata[12] = BUS_OWNED;
          next_state.rdata[13] = sel_s;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= '0;
      state.sync1 <= 8'hfc;
      state.sync2 <= 8'hfc;
      state.fsm <= ST_IDLE;
      state.area <= AREA_RESOURCE;
      state.br_n <= 1'b1;
      state.tx_thr <= TX_THR_RESET;
      state.rx_thr <= RX_THR_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Half-cycle early copy of the hold request for the falling-edge timing
  always_ff @(negedge CLK) begin
    if (RST) begin
      hold_fall <= 1'b0;
    end else begin
      hold_fall <= next_state.hold_req;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HOLD_REQUEST = state.late_edge ? state.hold_req : hold_fall;
  assign BUS_REQUEST_N = state.br_n;
  assign GRANT_ACKNOWLEDGE_N_OUT = 1'b0;
  assign GRANT_ACKNOWLEDGE_N_OE = state.grant_acknowledge_n;
  assign BUS_OWNED = (state.fsm == ST_DATA);
  assign MEM_CYCLE = state.mem_cycle;
  assign MEM_AREA = state.area;
  assign AREA_VALID = state.area_valid;
  assign DESC_DONE = state.desc_done;
  assign REG_RDATA = state.rdata;

endmodule : dma_bus_master_acquisition

// ==== sim/dma_acq_asserts.sv ====
// Port-level checks of the bus acquisition sequencer
`timescale 1ns/1ps
module dma_acq_asserts import dma_acq_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Handshake pins
  input wire logic BUS_PROTOCOL_SELECT,
  input wire logic HOLD_REQUEST,
  input wire logic HOLD_ACKNOWLEDGE,
  input wire logic BUS_REQUEST_N,
  input wire logic BUS_GRANT_N,
  input wire logic GRANT_ACKNOWLEDGE_N_IN,
  input wire logic GRANT_ACKNOWLEDGE_N_OE,
  input wire logic ADDRESS_STROBE_N,
  input wire logic [1:0] DATA_SIZE_ACK_N,
  // Block engine
  input wire logic [1:0] DESC_AREA,
  input wire logic [1:0] TX_DESC_LEN,
  input wire logic BUS_OWNED,
  input wire logic MEM_CYCLE,
  input wire logic [2:0] MEM_AREA,
  input wire logic CYCLE_DONE,
  input wire logic DESC_DONE
);
  logic [3:0] done_count;
  logic [3:0] want_count;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Counts descriptor words since the last finished block
  always_ff @(posedge CLK) begin
    if (RST || DESC_DONE) begin
      done_count <= 4'h0;
    end else if (CYCLE_DONE && MEM_CYCLE && MEM_AREA < 3'h4) begin
      done_count <= done_count + 4'h1;
    end
  end
  // Block length that the requested area calls for
  always_comb begin
    case (DESC_AREA)
      2'h0: want_count = RESOURCE_ACCESSES;
      2'h1: want_count = RX_DESC_ACCESSES;
      2'h2: want_count = TX_DESC_LEN == 2'h0 ? TX_DESC_SHORT :
        (TX_DESC_LEN == 2'h1 ? TX_DESC_MID : TX_DESC_LONG);
      default: want_count = MATCH_ACCESSES;
    endcase
  end
  a_hold_after_free: assert property ($rose(HOLD_REQUEST) |->
    !HOLD_ACKNOWLEDGE && !$past(HOLD_ACKNOWLEDGE)) else $error("hold raised during ack");
  a_hold_two_way: assert property (HOLD_REQUEST |-> !BUS_PROTOCOL_SELECT)
    else $error("hold in three-way mode");
  a_br_three_way: assert property (!BUS_REQUEST_N |-> BUS_PROTOCOL_SELECT)
    else $error("bus request in two-way mode");
  a_ack_before_data: assert property ($rose(BUS_OWNED) && !BUS_PROTOCOL_SELECT |->
    HOLD_REQUEST && $past(HOLD_ACKNOWLEDGE)) else $error("owned without ack");
  a_grant_before_data: assert property ($rose(BUS_OWNED) && BUS_PROTOCOL_SELECT |->
    !$past(BUS_GRANT_N)) else $error("owned without grant");
  a_bus_free_first: assert property ($rose(GRANT_ACKNOWLEDGE_N_OE) |->
    $past(ADDRESS_STROBE_N, 3) && $past(GRANT_ACKNOWLEDGE_N_IN, 3) &&
    $past(DATA_SIZE_ACK_N, 3) == 2'h3) else $error("bus taken while busy");
  a_owner_keeps_ack: assert property (BUS_OWNED && BUS_PROTOCOL_SELECT |->
    GRANT_ACKNOWLEDGE_N_OE) else $error("owned without grant ack");
  a_release_idle_state: assert property ($fell(GRANT_ACKNOWLEDGE_N_OE) |->
    !$past(BUS_OWNED) && $past(BUS_OWNED, 2)) else $error("no idle state on release");
  a_area_steady: assert property (BUS_OWNED && $past(BUS_OWNED) |-> $stable(MEM_AREA))
    else $error("area changed within block");
  a_cycle_in_block: assert property ($rose(MEM_CYCLE) |-> BUS_OWNED)
    else $error("memory cycle outside block");
  a_desc_length: assert property (DESC_DONE |-> done_count == want_count)
    else $error("descriptor block length wrong");
  c_two_way: cover property ($rose(BUS_OWNED) && !BUS_PROTOCOL_SELECT);
  c_three_way: cover property ($rose(BUS_OWNED) && BUS_PROTOCOL_SELECT);
  c_preempt: cover property (BUS_OWNED && !HOLD_ACKNOWLEDGE && !BUS_PROTOCOL_SELECT);
endmodule : dma_acq_asserts

bind dma_bus_master_acquisition dma_acq_asserts chk (.CLK, .RST, .BUS_PROTOCOL_SELECT,
  .HOLD_REQUEST, .HOLD_ACKNOWLEDGE, .BUS_REQUEST_N, .BUS_GRANT_N, .GRANT_ACKNOWLEDGE_N_IN,
  .GRANT_ACKNOWLEDGE_N_OE, .ADDRESS_STROBE_N, .DATA_SIZE_ACK_N, .DESC_AREA, .TX_DESC_LEN,
  .BUS_OWNED, .MEM_CYCLE, .MEM_AREA, .CYCLE_DONE, .DESC_DONE);

// ==== sim/dma_acq_far_side.sv ====
// Arbiter, other bus master and memory model facing the acquisition block
`timescale 1ns/1ps
module dma_acq_far_side (
  // Clock, reset and scenario controls
  input wire logic CLK,
  input wire logic RST,
  input wire logic preempt,
  input wire logic hog,
  input wire logic busy,
  // Device pins
  input wire logic HOLD_REQUEST,
  input wire logic BUS_REQUEST_N,
  input wire logic GRANT_ACKNOWLEDGE_N_OE,
  input wire logic MEM_CYCLE,
  output logic HOLD_ACKNOWLEDGE,
  output logic BUS_GRANT_N,
  output logic GRANT_ACKNOWLEDGE_N_IN,
  output logic ADDRESS_STROBE_N,
  output logic [1:0] DATA_SIZE_ACK_N,
  output logic SYNC_CYCLE_TERMINATE_N,
  output logic CYCLE_DONE
);
  logic [1:0] wait_count;
  logic [1:0] word_count;
  logic acked;
  logic granted;
  // Answers a request after arbitration delay; memory takes four cycles a word
  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_count <= 2'h0;
      word_count <= 2'h0;
      acked <= 1'h0;
      granted <= 1'h0;
      CYCLE_DONE <= 1'h0;
    end else begin
      wait_count <= (HOLD_REQUEST || !BUS_REQUEST_N) && !acked && !granted ?
        wait_count + 2'h1 : 2'h0;
      acked <= HOLD_REQUEST && !preempt && (acked || wait_count == 2'h3);
      granted <= !BUS_REQUEST_N && !GRANT_ACKNOWLEDGE_N_OE &&
        (granted || wait_count == 2'h3);
      word_count <= MEM_CYCLE && !CYCLE_DONE ? word_count + 2'h1 : 2'h0;
      CYCLE_DONE <= word_count == 2'h2;
    end
  end
  // Another master may hold the bus; its lines have pull-ups when released
  assign HOLD_ACKNOWLEDGE = acked || hog;
  assign BUS_GRANT_N = !granted;
  assign GRANT_ACKNOWLEDGE_N_IN = !(GRANT_ACKNOWLEDGE_N_OE || busy);
  assign ADDRESS_STROBE_N = !busy;
  assign DATA_SIZE_ACK_N = {2{!busy}};
  assign SYNC_CYCLE_TERMINATE_N = !busy;
endmodule : dma_acq_far_side

// ==== sim/test_dma_bus_master_acquisition.sv ====
// Self-checking bench of the bus acquisition sequencer
`timescale 1ns/1ps
module test_dma_bus_master_acquisition;
  import dma_acq_pkg::*;
  logic CLK = 1'h0, RST = 1'h1, REG_WRITE = 1'h0, REG_READ = 1'h0, DESC_REQ = 1'h0;
  logic BUS_PROTOCOL_SELECT = 1'h0, preempt = 1'h0, hog = 1'h0, busy = 1'h0, late = 1'h0;
  logic [7:0] REG_ADDR = 8'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, v;
  logic [4:0] TX_LEVEL = 5'h10, RX_LEVEL = 5'h0;
  logic [1:0] DESC_AREA = 2'h0, TX_DESC_LEN = 2'h0, DATA_SIZE_ACK_N;
  logic [2:0] MEM_AREA;
  logic HOLD_REQUEST, HOLD_ACKNOWLEDGE, BUS_REQUEST_N, BUS_GRANT_N, GRANT_ACKNOWLEDGE_N_IN;
  logic GRANT_ACKNOWLEDGE_N_OE, ADDRESS_STROBE_N, SYNC_CYCLE_TERMINATE_N, BUS_OWNED;
  logic MEM_CYCLE, AREA_VALID, CYCLE_DONE, DESC_DONE, GRANT_ACKNOWLEDGE_N_OUT;
  int bad_count = 0, checks_done = 0, words = 0, cyc = 0, i;
  int want[6] = '{4, 7, 2, 3, 6, 4};
  dma_bus_master_acquisition uut (.CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ,
    .REG_RDATA, .BUS_PROTOCOL_SELECT, .HOLD_REQUEST, .HOLD_ACKNOWLEDGE, .BUS_REQUEST_N,
    .BUS_GRANT_N, .GRANT_ACKNOWLEDGE_N_IN, .GRANT_ACKNOWLEDGE_N_OUT, .GRANT_ACKNOWLEDGE_N_OE,
    .ADDRESS_STROBE_N, .DATA_SIZE_ACK_N, .SYNC_CYCLE_TERMINATE_N, .TX_LEVEL, .RX_LEVEL,
    .DESC_REQ, .DESC_AREA, .TX_DESC_LEN, .BUS_OWNED, .MEM_CYCLE, .MEM_AREA, .AREA_VALID,
    .CYCLE_DONE, .DESC_DONE);
  dma_acq_far_side far (.CLK, .RST, .preempt, .hog, .busy, .HOLD_REQUEST, .BUS_REQUEST_N,
    .GRANT_ACKNOWLEDGE_N_OE, .MEM_CYCLE, .HOLD_ACKNOWLEDGE, .BUS_GRANT_N,
    .GRANT_ACKNOWLEDGE_N_IN, .ADDRESS_STROBE_N, .DATA_SIZE_ACK_N, .SYNC_CYCLE_TERMINATE_N,
    .CYCLE_DONE);
  // Clock
  initial begin
    forever #5 CLK = ~CLK;
  end
  // FIFO levels follow the words moved; cycle ceiling cuts a hang
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (CYCLE_DONE && MEM_AREA == AREA_RX_BUF) RX_LEVEL <= RX_LEVEL - 5'h1;
    if (CYCLE_DONE && MEM_AREA == AREA_TX_BUF) TX_LEVEL <= TX_LEVEL + 5'h1;
    if (CYCLE_DONE) words <= words + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  // Edge on which hold goes up
  always @(posedge HOLD_REQUEST) if (!RST) check(CLK, late);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK) {REG_ADDR, REG_WDATA, REG_WRITE} <= {a, d, 1'h1};
    @(posedge CLK) REG_WRITE <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK) {REG_ADDR, REG_READ} <= {a, 1'h1};
    @(posedge CLK) REG_READ <= 1'h0;
    @(negedge CLK) d = REG_RDATA;
  endtask : rd
  // Bounded wait for a level, sampled once the edge has settled
  task automatic await(ref logic s, input logic lvl);
    int n = 0;
    do begin
      @(posedge CLK) #1 n++;
    end while (n < 400 && s !== lvl);
    check(s, lvl);
  endtask : await
  task reset_dut(input logic sel);
    @(posedge CLK) {RST, BUS_PROTOCOL_SELECT, DESC_REQ, preempt} <= {1'h1, sel, 2'h0};
    repeat (10) @(posedge CLK);
    RST <= 1'h0;
    late = 1'h0;
  endtask : reset_dut
  task automatic desc(input logic [1:0] area, input logic [1:0] len, input int exp);
    @(posedge CLK) {DESC_AREA, TX_DESC_LEN, DESC_REQ} <= {area, len, 1'h1};
    words = 0;
    await(DESC_DONE, 1'h1);
    @(posedge CLK) DESC_REQ <= 1'h0;
    check(words, exp);
  endtask : desc
  task automatic fifo_run(input logic [31:0] cfg, input logic [4:0] rx, input logic [4:0] tx,
      input int exp);
    wr(DATA_CONFIG_OFFSET, cfg);
    @(posedge CLK) {RX_LEVEL, TX_LEVEL} <= {rx, tx};
    words = 0;
    await(BUS_OWNED, 1'h1);
    await(BUS_OWNED, 1'h0);
    repeat (8) @(posedge CLK);
    check(words, exp);
  endtask : fifo_run
  task summarize();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    reset_dut(1'h0);
    rd(DATA_CONFIG_OFFSET, v);
    check(v, 32'h44);
    rd(8'h0c, v);
    check(v, 32'h0);
    $display("register test done");
    for (i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr(SECOND_DATA_CONFIG_OFFSET, 32'h1);
        late = 1'h1;
      end
      desc(2'(i < 2 ? i : (i < 5 ? 2 : 3)), 2'(i - 2), want[i]);
    end
    rd(SECOND_DATA_CONFIG_OFFSET, v);
    check(v, 32'h1);
    @(posedge CLK) hog <= 1'h1;
    fork
      desc(2'h0, 2'h0, 4);
      begin
        repeat (8) @(posedge CLK);
        #1 check(HOLD_REQUEST, 1'h0);
        @(posedge CLK) hog <= 1'h0;
      end
    join
    $display("descriptor tests done");
    fifo_run(32'h40, 5'h6, 5'h10, 4);
    fifo_run(32'h140, 5'h6, 5'h10, 6);
    fifo_run(32'h4, 5'h0, 5'ha, 4);
    fifo_run(32'h104, 5'h0, 5'ha, 6);
    $display("block size tests done");
    @(posedge CLK) {DESC_AREA, DESC_REQ} <= {2'h1, 1'h1};
    await(BUS_OWNED, 1'h1);
    @(posedge CLK) preempt <= 1'h1;
    await(HOLD_REQUEST, 1'h0);
    for (i = 0; i < 9 && HOLD_REQUEST !== 1'h1; i++) @(posedge CLK) #1;
    check(i, 1);
    reset_dut(1'h0);
    @(posedge CLK) {DESC_AREA, DESC_REQ} <= {2'h3, 1'h1};
    await(BUS_OWNED, 1'h1);
    @(posedge CLK) preempt <= 1'h1;
    repeat (8) @(posedge CLK);
    #1 check({HOLD_REQUEST, AREA_VALID, BUS_OWNED}, 3'h4);
    rd(STATUS_OFFSET, v);
    check({v[12], v[6:4]}, 4'h3);
    @(posedge CLK) preempt <= 1'h0;
    await(DESC_DONE, 1'h1);
    @(posedge CLK) DESC_REQ <= 1'h0;
    wr(DATA_CONFIG_OFFSET, 32'h40);
    @(posedge CLK) RX_LEVEL <= 5'h4;
    await(CYCLE_DONE, 1'h1);
    @(posedge CLK) preempt <= 1'h1;
    await(BUS_OWNED, 1'h0);
    @(posedge CLK) preempt <= 1'h0;
    repeat (10) @(posedge CLK);
    #1 check(HOLD_REQUEST, 1'h0);
    $display("preemption tests done");
    @(posedge CLK) {RX_LEVEL, busy} <= {5'h0, 1'h1};
    reset_dut(1'h1);
    @(posedge CLK) {DESC_AREA, DESC_REQ} <= {2'h0, 1'h1};
    words = 0;
    await(BUS_REQUEST_N, 1'h0);
    await(BUS_GRANT_N, 1'h0);
    repeat (6) @(posedge CLK);
    #1 check(GRANT_ACKNOWLEDGE_N_OE, 1'h0);
    @(posedge CLK) busy <= 1'h0;
    await(GRANT_ACKNOWLEDGE_N_OE, 1'h1);
    check(GRANT_ACKNOWLEDGE_N_OUT, 1'h0);
    await(DESC_DONE, 1'h1);
    check(words, 4);
    $display("three-way test done");
    summarize();
  end
endmodule : test_dma_bus_master_acquisition
